// *** hdl/timer16_cfg_decode.sv ***
// decodes the stored mode, clock and filter fields into selections
// assumes power-mode inputs are already synchronous to clk

`timescale 1ns/1ps

module timer16_cfg_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    timer16_cfg_if.dec cfg
);

    timer16_pkg::dec_t r_ff;
    timer16_pkg::dec_t nxt_r;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        case (cfg.modeSel)
            3'h0, 3'h1: nxt_r.opMode = timer16_pkg::OP_TIMER;
            3'h2: nxt_r.opMode = timer16_pkg::OP_EVENT;
            3'h3: nxt_r.opMode = timer16_pkg::OP_PPG;
            3'h4: nxt_r.opMode = timer16_pkg::OP_EXTTRIG;
            3'h5: nxt_r.opMode = timer16_pkg::OP_WINDOW;
            3'h6: nxt_r.opMode = timer16_pkg::OP_PWM;
            default: nxt_r.opMode = timer16_pkg::OP_RESERVED;
        endcase
        // source clock choice; slow mode only has the low clock
        if ((cfg.slowMode || cfg.divOpt) && cfg.clkSel == 2'h0) begin
            nxt_r.src = timer16_pkg::SRC_LOWF8;
        end else if (cfg.slowMode) begin
            nxt_r.src = timer16_pkg::SRC_NONE;
        end else begin
            case (cfg.clkSel)
                2'h0: nxt_r.src = timer16_pkg::SRC_GEAR1024;
                2'h1: nxt_r.src = timer16_pkg::SRC_GEAR64;
                2'h2: nxt_r.src = timer16_pkg::SRC_GEAR4;
                default: nxt_r.src = timer16_pkg::SRC_GEAR2;
            endcase
        end
        // filter interval; short codes halt the filter in slow
        case (cfg.nfSel)
            2'h0: nxt_r.nf = timer16_pkg::NF_OFF;
            2'h3: nxt_r.nf = cfg.slowMode ? timer16_pkg::NF_LOWF2 : timer16_pkg::NF_GEAR256;
            2'h1: nxt_r.nf = cfg.slowMode ? timer16_pkg::NF_HALT : timer16_pkg::NF_GEAR2;
            default: nxt_r.nf = cfg.slowMode ? timer16_pkg::NF_HALT : timer16_pkg::NF_GEAR4;
        endcase
        nxt_r.nfHalt = (nxt_r.nf == timer16_pkg::NF_HALT);
        // auto capture only in the counting modes
        nxt_r.acapActive = cfg.acap && (nxt_r.opMode == timer16_pkg::OP_TIMER
            || nxt_r.opMode == timer16_pkg::OP_EVENT
            || nxt_r.opMode == timer16_pkg::OP_EXTTRIG
            || nxt_r.opMode == timer16_pkg::OP_WINDOW);
    end

    // registered so every selection leaves from a flip-flop
    always_ff @(posedge clk) begin
        if (rst) begin
            r_ff <= '{opMode: timer16_pkg::OP_TIMER, src: timer16_pkg::SRC_GEAR1024,
                      nf: timer16_pkg::NF_OFF, nfHalt: 1'b0, acapActive: 1'b0};
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    assign cfg.opMode = r_ff.opMode;
    assign cfg.src = r_ff.src;
    assign cfg.nf = r_ff.nf;
    assign cfg.nfHalt = r_ff.nfHalt;
    assign cfg.acapActive = r_ff.acapActive;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_mode_pwm_decode: assert property (
        ce && cfg.modeSel == 3'h6 |=> cfg.opMode == timer16_pkg::OP_PWM)
        else $error("mode code 110 not decoded as pulse width");
    chk_src_slow_low: assert property (
        ce && cfg.slowMode && cfg.clkSel == 2'h0 |=> cfg.src == timer16_pkg::SRC_LOWF8)
        else $error("slow mode code 00 not low clock over 8");
    chk_filter_halt_slow: assert property (
        ce && cfg.slowMode && (cfg.nfSel == 2'h1 || cfg.nfSel == 2'h2) |=> cfg.nfHalt)
        else $error("filter not halted for short code in slow mode");
    chk_capture_mode_gate: assert property (
        cfg.acapActive |-> cfg.opMode != timer16_pkg::OP_PWM && cfg.opMode != timer16_pkg::OP_PPG)
        else $error("auto capture active in a mode without it");

endmodule : timer16_cfg_decode

// *** hdl/timer16_cfg_if.sv ***
// configuration fields going to the decoder and decoded selections back
// assumes both ends run on the same clock

`timescale 1ns/1ps

interface timer16_cfg_if;
    logic [2:0] modeSel;
    logic [1:0] clkSel;
    logic [1:0] nfSel;
    logic slowMode;
    logic divOpt;
    logic acap;
    timer16_pkg::opmode_t opMode;
    timer16_pkg::srcclk_t src;
    timer16_pkg::nfsel_t nf;
    logic nfHalt;
    logic acapActive;

    modport ctl (output modeSel, clkSel, nfSel, slowMode, divOpt, acap,
                 input opMode, src, nf, nfHalt, acapActive);
    modport dec (input modeSel, clkSel, nfSel, slowMode, divOpt, acap,
                 output opMode, src, nf, nfHalt, acapActive);
endinterface : timer16_cfg_if

// *** hdl/timer16_mode_control_regs.sv ***
// control registers of one 16-bit timer channel: mode, run control,
// clock gating and a small interrupt block, on a classic wishbone slave
// assumes power-mode and counter inputs come from logic on clk
//
// The Wishbone interface to the registers was chosen for this implementation.

`timescale 1ns/1ps

module timer16_mode_control_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [timer16_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic slowMode,
    input wire logic divOption,
    input wire logic stopEnter,
    input wire logic counterOverflow,
    output timer16_pkg::opmode_t opMode,
    output timer16_pkg::srcclk_t srcClock,
    output timer16_pkg::nfsel_t noiseSel,
    output logic noiseHalt,
    output logic autoCaptureActive,
    output logic oneShotSel,
    output logic dblBufEnable,
    output logic trigFallingSel,
    output logic pulseSingleEdge,
    output logic trigStopEnable,
    output logic ffInitLevel,
    output logic countEnable,
    output logic counterClear,
    output logic timerIrqReq,
    output logic [3:0] gateEnables,
    output logic irq
);

    timer16_pkg::regs_t r_ff;
    timer16_pkg::regs_t nxt_r;
    timer16_cfg_if cfg ();

    logic [11:0] idx;
    logic reqNew;
    logic wrNow;
    logic wrMode;
    logic wrCtrl;
    logic running;
    logic [7:0] wd;
    logic [7:0] rdMux;
    logic [timer16_pkg::IRQ_W-1:0] events;
    logic [timer16_pkg::IRQ_W-1:0] clrMask;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // one wait state: ack follows the first request cycle, writes land
    // on the acknowledging edge so the master's held data is used
    assign idx = adr_i[timer16_pkg::ADR_W-1:2];
    assign reqNew = cyc_i && stb_i && !r_ff.ack;
    // byte lane zero carries the register
    assign wrNow = cyc_i && stb_i && r_ff.ack && we_i && sel_i[0];
    assign wrMode = wrNow && idx == timer16_pkg::IDX_MODE;
    assign wrCtrl = wrNow && idx == timer16_pkg::IDX_CTRL;
    assign running = (r_ff.run == timer16_pkg::RUN_GO);
    assign wd = dat_i[7:0];

    // read multiplexer; unmapped addresses answer with zero
    always_comb begin
        rdMux = 8'h00;
        case (idx)
            timer16_pkg::IDX_MODE: rdMux = r_ff.mode;
            // the two unused bits always read zero
            timer16_pkg::IDX_CTRL: rdMux = {r_ff.ove, r_ff.tff, r_ff.nc, 2'h0,
                                            r_ff.acap, r_ff.run};
            timer16_pkg::IDX_GATE: rdMux = r_ff.gate;
            timer16_pkg::IDX_IRQ_STS: rdMux = {5'h00, r_ff.sts};
            timer16_pkg::IDX_IRQ_EN: rdMux = {5'h00, r_ff.en};
            default: rdMux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    // a locked write is flagged so software sees a lost configuration
    always_comb begin
        events = '0;
        events[timer16_pkg::IRQ_OVF] = counterOverflow;
        events[timer16_pkg::IRQ_STOP] = stopEnter && running;
        events[timer16_pkg::IRQ_LOCK] = running && (wrMode || (wrCtrl
            && wd[7:4] != {r_ff.ove, r_ff.tff, r_ff.nc}));
        clrMask = '0;
        if (wrNow && idx == timer16_pkg::IDX_IRQ_CLR) begin
            clrMask = wd[timer16_pkg::IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        nxt_r.ack = reqNew;
        nxt_r.clrPulse = 1'b0;
        if (reqNew) begin
            nxt_r.rdat = rdMux;
        end
        // mode register frozen while the channel runs
        if (wrMode && !running) begin
            nxt_r.mode = wd;
        end
        if (wrCtrl) begin
            // locked fields only change from the stopped state
            if (!running) begin
                nxt_r.ove = wd[timer16_pkg::CR_OVE];
                nxt_r.tff = wd[timer16_pkg::CR_TFF];
                nxt_r.nc = wd[timer16_pkg::CR_NC_LO+:2];
            end
            nxt_r.acap = wd[timer16_pkg::CR_ACAP];
            // one starts, zero stops and clears the count
            if (wd[timer16_pkg::CR_S]) begin
                nxt_r.run = timer16_pkg::RUN_GO;
            end else begin
                nxt_r.run = timer16_pkg::RUN_STOP;
                nxt_r.clrPulse = 1'b1;
            end
        end
        // stop mode entry wins over a start in the same cycle
        if (stopEnter) begin
            nxt_r.run = timer16_pkg::RUN_STOP;
            nxt_r.clrPulse = 1'b1;
        end
        // all gating bits writable, reset to zero
        if (wrNow && idx == timer16_pkg::IDX_GATE) begin
            nxt_r.gate = wd;
        end
        if (wrNow && idx == timer16_pkg::IDX_IRQ_EN) begin
            nxt_r.en = wd[timer16_pkg::IRQ_W-1:0];
        end
        // new events beat a clear landing in the same cycle
        nxt_r.sts = (r_ff.sts & ~clrMask) | events;
        // request only with the overflow enable set
        nxt_r.irqReq = counterOverflow && r_ff.ove;
    end

    // single register stage for the block's own state, frozen by ce; the decoder adds a second flop for its selections
    always_ff @(posedge clk) begin
        if (rst) begin
            r_ff <= '{ack: 1'b0, rdat: 8'h00, mode: timer16_pkg::RST_MODE,
                      ove: timer16_pkg::RST_CTRL[timer16_pkg::CR_OVE],
                      tff: timer16_pkg::RST_CTRL[timer16_pkg::CR_TFF],
                      nc: timer16_pkg::RST_CTRL[timer16_pkg::CR_NC_LO+:2],
                      acap: timer16_pkg::RST_CTRL[timer16_pkg::CR_ACAP],
                      run: timer16_pkg::RUN_STOP, gate: timer16_pkg::RST_GATE,
                      sts: '0, en: '0, irqReq: 1'b0, clrPulse: 1'b0};
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------------
    // decoder
    // ------------------------------------------------------------------
    assign cfg.modeSel = r_ff.mode[timer16_pkg::MOD_M_LO+:3];
    assign cfg.clkSel = r_ff.mode[timer16_pkg::MOD_CK_LO+:2];
    assign cfg.nfSel = r_ff.nc;
    assign cfg.slowMode = slowMode;
    assign cfg.divOpt = divOption;
    assign cfg.acap = r_ff.acap;

    timer16_cfg_decode u_decode (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .cfg(cfg.dec)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dat_o = {24'h000000, r_ff.rdat};
    assign ack_o = r_ff.ack;
    assign opMode = cfg.opMode;
    assign srcClock = cfg.src;
    assign noiseSel = cfg.nf;
    assign noiseHalt = cfg.nfHalt;
    assign autoCaptureActive = cfg.acapActive;
    assign oneShotSel = r_ff.acap;
    // mode bits and the control flip-flop level passed to the counting core
    assign dblBufEnable = r_ff.mode[timer16_pkg::MOD_DBE];
    assign trigFallingSel = r_ff.mode[timer16_pkg::MOD_TED];
    assign pulseSingleEdge = r_ff.mode[timer16_pkg::MOD_MCAP];
    assign trigStopEnable = r_ff.mode[timer16_pkg::MOD_METT];
    assign ffInitLevel = r_ff.tff;
    // no basic clock for channel zero while its gate is off
    assign countEnable = running && r_ff.gate[timer16_pkg::GATE_CH0];
    assign counterClear = r_ff.clrPulse;
    assign timerIrqReq = r_ff.irqReq;
    assign gateEnables = {r_ff.gate[timer16_pkg::GATE_PAIR1], r_ff.gate[timer16_pkg::GATE_PAIR0],
                          r_ff.gate[timer16_pkg::GATE_CH1], r_ff.gate[timer16_pkg::GATE_CH0]};
    assign irq = |(r_ff.sts & r_ff.en);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_stop_entry;
        ce && stopEnter;
    endsequence

    sequence seq_run_write;
        ce && wrCtrl && wd[timer16_pkg::CR_S] && !stopEnter;
    endsequence

    chk_mode_write_lock: assert property (
        ce && wrMode && running |=> $stable(r_ff.mode))
        else $error("mode register changed while running");
    chk_field_write_lock: assert property (
        ce && wrCtrl && running |=> $stable({r_ff.ove, r_ff.tff, r_ff.nc}))
        else $error("locked control field changed while running");
    chk_stop_entry_clear: assert property (
        seq_stop_entry |=> !running && counterClear ##1 !counterClear || !ce)
        else $error("stop entry did not halt the channel");
    chk_ctrl_read_zero: assert property (
        ack_o && idx == timer16_pkg::IDX_CTRL |-> dat_o[3:2] == 2'h0)
        else $error("control bits 3 and 2 read nonzero");
    chk_run_start: assert property (
        seq_run_write |=> running && !counterClear)
        else $error("start write did not set the run state");
    chk_overflow_request: assert property (
        ce && counterOverflow |=> timerIrqReq == $past(r_ff.ove))
        else $error("overflow request disagrees with its enable");
    chk_gate_halt: assert property (
        ce && wrNow && idx == timer16_pkg::IDX_GATE && !wd[0] |=> !countEnable)
        else $error("channel counts with its clock gated off");
    chk_bus_ack_pulse: assert property (
        ce && reqNew |=> ack_o ##1 (!ack_o || !$past(ce)))
        else $error("bus ack not a single cycle after request");

endmodule : timer16_mode_control_regs

// *** hdl/timer16_pkg.sv ***
// constants, types and register map of the 16-bit timer control block
// assumes a 32-bit classic wishbone bus, each 8-bit register in the low
// byte of one aligned word at byte address four times its index

package timer16_pkg;

    // ------------------------------------------------------------------
    // register map (indices, byte address = index * 4)
    // ------------------------------------------------------------------
    localparam int ADR_W = 14;
    localparam logic [11:0] IDX_MODE = 12'h031;
    localparam logic [11:0] IDX_CTRL = 12'h032;
    localparam logic [11:0] IDX_GATE = 12'hF74;
    localparam logic [11:0] IDX_IRQ_STS = 12'h040;
    localparam logic [11:0] IDX_IRQ_EN = 12'h041;
    localparam logic [11:0] IDX_IRQ_CLR = 12'h042;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE = 8'h80;
    localparam logic [7:0] RST_CTRL = 8'h40;
    localparam logic [7:0] RST_GATE = 8'h00;

    // ------------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------------
    localparam int MOD_DBE = 7;
    localparam int MOD_TED = 6;
    localparam int MOD_MCAP = 5;   // shares its bit with the trigger stop enable
    localparam int MOD_METT = 5;
    localparam int MOD_CK_LO = 3;
    localparam int MOD_M_LO = 0;

    // ------------------------------------------------------------------
    // run control register fields
    // ------------------------------------------------------------------
    localparam int CR_OVE = 7;
    localparam int CR_TFF = 6;
    localparam int CR_NC_LO = 4;
    localparam int CR_ACAP = 1;    // shares its bit with the one-shot select
    localparam int CR_MPPG = 1;
    localparam int CR_S = 0;

    // ------------------------------------------------------------------
    // clock gating bits and interrupt status bits
    // ------------------------------------------------------------------
    localparam int GATE_CH0 = 0;
    localparam int GATE_CH1 = 1;
    localparam int GATE_PAIR0 = 4;
    localparam int GATE_PAIR1 = 5;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_LOCK = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_TIMER = 3'h0, OP_EVENT = 3'h1, OP_PPG = 3'h3, OP_EXTTRIG = 3'h2,
        OP_WINDOW = 3'h6, OP_PWM = 3'h7, OP_RESERVED = 3'h5
    } opmode_t;

    typedef enum logic [2:0] {
        SRC_GEAR1024 = 3'h0, SRC_GEAR64 = 3'h1, SRC_GEAR4 = 3'h3,
        SRC_GEAR2 = 3'h2, SRC_LOWF8 = 3'h6, SRC_NONE = 3'h7
    } srcclk_t;

    typedef enum logic [2:0] {
        NF_OFF = 3'h0, NF_GEAR2 = 3'h1, NF_GEAR4 = 3'h3, NF_GEAR256 = 3'h2,
        NF_LOWF2 = 3'h6, NF_HALT = 3'h7
    } nfsel_t;

    typedef enum logic [0:0] {
        RUN_STOP = 1'h0, RUN_GO = 1'h1
    } runstate_t;

    // ------------------------------------------------------------------
    // state records
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic [7:0] mode;
        logic ove;
        logic tff;
        logic [1:0] nc;
        logic acap;
        runstate_t run;
        logic [7:0] gate;
        logic [IRQ_W-1:0] sts;
        logic [IRQ_W-1:0] en;
        logic irqReq;
        logic clrPulse;
    } regs_t;

    typedef struct packed {
        opmode_t opMode;
        srcclk_t src;
        nfsel_t nf;
        logic nfHalt;
        logic acapActive;
    } dec_t;

endpackage : timer16_pkg

// *** sim/timer16_mode_control_regs_tb.sv ***
// bench for the timer control registers: wishbone tasks and port checks
// assumes one 50 MHz clock, synchronous reset, one request at a time
`timescale 1ns/1ps

module timer16_mode_control_regs_tb;
    logic clk = 0, rst = 1, req = 0, we = 0, slowMode = 0, divOption = 0, stopEnter = 0, ovf = 0;
    logic [13:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic [3:0] gates, sel = 4'hF;
    logic ack, irq, cntEn, clrP, irqP, nh, acap, osh, dbe, tfs, pse, tse, ffi, ce = 1;
    logic [2:0] opm, src, nsel;
    logic [7:0] q;
    int bad_count = 0, check_count = 0, cycN = 0, clrs = 0, reqs = 0, c0, r0;

    timer16_mode_control_regs timer16_mode_control_regs_i (.clk(clk), .rst(rst), .ce(ce),
        .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .slowMode(slowMode), .divOption(divOption),
        .stopEnter(stopEnter), .counterOverflow(ovf), .opMode(opm), .srcClock(src),
        .noiseSel(nsel), .noiseHalt(nh), .autoCaptureActive(acap), .oneShotSel(osh),
        .dblBufEnable(dbe), .trigFallingSel(tfs), .pulseSingleEdge(pse),
        .trigStopEnable(tse), .ffInitLevel(ffi), .countEnable(cntEn), .counterClear(clrP),
        .timerIrqReq(irqP), .gateEnables(gates), .irq(irq));

    initial begin
        forever #10 clk = ~clk;
    end

    // pulse counters and the hang limit
    always @(posedge clk) begin
        cycN++;
        if (clrP === 1'b1) clrs++;
        if (irqP === 1'b1) reqs++;
        if (cycN == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one classic cycle; request held until the edge that samples ack high,
    // read data taken and request dropped at that same edge
    task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        req <= 1'b0;
    endtask : bus

    task automatic rd(input logic [11:0] idx, input logic [7:0] exp, input string nm);
        bus(1'b0, idx, 8'h00);
        chk(nm, q, exp);
    endtask : rd

    // decoded outputs trail the register by one extra flop
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic pulse(input bit stp);
        @(posedge clk);
        if (stp) stopEnter <= 1'b1; else ovf <= 1'b1;
        @(posedge clk);
        stopEnter <= 1'b0;
        ovf <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse

    function automatic logic [2:0] opx(input int m);
        case (m)
            0, 1: return timer16_pkg::OP_TIMER;
            2: return timer16_pkg::OP_EVENT;
            3: return timer16_pkg::OP_PPG;
            4: return timer16_pkg::OP_EXTTRIG;
            5: return timer16_pkg::OP_WINDOW;
            6: return timer16_pkg::OP_PWM;
            default: return timer16_pkg::OP_RESERVED;
        endcase
    endfunction : opx

    // index bits: 1:0 code, 2 divider option, 3 slow mode
    function automatic logic [2:0] srcx(input logic [3:0] s);
        if (s[1:0] == 0) return (s[3] | s[2]) ? timer16_pkg::SRC_LOWF8 : timer16_pkg::SRC_GEAR1024;
        if (s[3]) return timer16_pkg::SRC_NONE;
        case (s[1:0])
            1: return timer16_pkg::SRC_GEAR64;
            2: return timer16_pkg::SRC_GEAR4;
            default: return timer16_pkg::SRC_GEAR2;
        endcase
    endfunction : srcx

    function automatic logic [2:0] nfx(input logic [2:0] s);
        if (s[1:0] == 0) return timer16_pkg::NF_OFF;
        if (s[2]) return (s[1:0] == 3) ? timer16_pkg::NF_LOWF2 : timer16_pkg::NF_HALT;
        case (s[1:0])
            1: return timer16_pkg::NF_GEAR2;
            2: return timer16_pkg::NF_GEAR4;
            default: return timer16_pkg::NF_GEAR256;
        endcase
    endfunction : nfx

    task automatic t_decode;
        bus(1'b1, timer16_pkg::IDX_CTRL, 8'h42);
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, timer16_pkg::IDX_MODE, 8'(m));
            settle();
            chk("opMode", opm, opx(m));
            chk("autoCapture", acap, 8'(m < 3 || m == 4 || m == 5));
        end
        for (int s = 0; s < 16; s++) begin
            @(posedge clk);
            slowMode <= s[3];
            divOption <= s[2];
            bus(1'b1, timer16_pkg::IDX_MODE, {3'h0, 2'(s), 3'h0});
            settle();
            chk("srcClock", src, srcx(4'(s)));
        end
        divOption <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            slowMode <= s[2];
            bus(1'b1, timer16_pkg::IDX_CTRL, {2'b01, 2'(s), 4'h0});
            settle();
            chk("noiseSel", nsel, nfx(3'(s)));
            chk("noiseHalt", nh, 8'(s[2] && (s[1] ^ s[0])));
        end
        slowMode <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, timer16_pkg::IDX_MODE, {{3{i[0]}}, 5'h00});
            bus(1'b1, timer16_pkg::IDX_CTRL, {1'b0, i[0], 4'h0, i[0], 1'b0});
            settle();
            chk("dblBuf", dbe, 8'(i));
            chk("trigFalling", tfs, 8'(i));
            chk("singleEdge", pse, 8'(i));
            chk("trigStop", tse, 8'(i));
            chk("oneShot", osh, 8'(i));
            chk("ffInit", ffi, 8'(i));
        end
    endtask : t_decode

    task automatic t_run;
        bus(1'b1, timer16_pkg::IDX_MODE, 8'h00);
        bus(1'b1, timer16_pkg::IDX_GATE, 8'h01);
        bus(1'b1, timer16_pkg::IDX_IRQ_EN, 8'h07);
        bus(1'b1, timer16_pkg::IDX_CTRL, 8'h81);
        rd(timer16_pkg::IDX_CTRL, 8'h81, "ctrl started");
        chk("countEnable", cntEn, 8'h01);
        bus(1'b1, timer16_pkg::IDX_MODE, 8'h05);
        rd(timer16_pkg::IDX_MODE, 8'h00, "mode locked");
        bus(1'b1, timer16_pkg::IDX_CTRL, 8'h41);
        rd(timer16_pkg::IDX_CTRL, 8'h81, "ctrl locked");
        r0 = reqs;
        pulse(1'b0);
        chk("irqReq on", 8'(reqs - r0), 8'h01);
        c0 = clrs;
        pulse(1'b1);
        chk("stop clear", 8'(clrs - c0), 8'h01);
        rd(timer16_pkg::IDX_CTRL, 8'h80, "ctrl stop mode");
        chk("stopped", cntEn, 8'h00);
        rd(timer16_pkg::IDX_IRQ_STS, 8'h07, "status");
        chk("irq", irq, 8'h01);
        bus(1'b1, timer16_pkg::IDX_IRQ_EN, 8'h00);
        settle();
        chk("irq masked", irq, 8'h00);
        bus(1'b1, timer16_pkg::IDX_IRQ_EN, 8'h07);
        bus(1'b1, timer16_pkg::IDX_IRQ_CLR, 8'h07);
        rd(timer16_pkg::IDX_IRQ_STS, 8'h00, "status cleared");
        chk("irq cleared", irq, 8'h00);
        c0 = clrs;
        bus(1'b1, timer16_pkg::IDX_CTRL, 8'h00);
        settle();
        chk("stop write clear", 8'(clrs - c0), 8'h01);
        r0 = reqs;
        pulse(1'b0);
        chk("irqReq off", 8'(reqs - r0), 8'h00);
    endtask : t_run

    task automatic t_gate;
        bus(1'b1, timer16_pkg::IDX_CTRL, 8'h41);
        bus(1'b1, timer16_pkg::IDX_GATE, 8'h33);
        settle();
        chk("gates all", gates, 8'h0F);
        chk("gated on", cntEn, 8'h01);
        // a stop entry while ce is low must leave every flop untouched
        @(posedge clk);
        ce <= 1'b0;
        stopEnter <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        stopEnter <= 1'b0;
        settle();
        chk("ce freeze", cntEn, 8'h01);
        bus(1'b1, timer16_pkg::IDX_GATE, 8'hF2);
        settle();
        chk("gates", gates, 8'h0E);
        chk("gated off", cntEn, 8'h00);
        rd(timer16_pkg::IDX_GATE, 8'hF2, "gate reg");
        // a write without byte lane zero must not land
        sel <= 4'hE;
        bus(1'b1, timer16_pkg::IDX_GATE, 8'h00);
        sel <= 4'hF;
        rd(timer16_pkg::IDX_GATE, 8'hF2, "lane zero off");
        // still running here, so the flip-flop bit stays set
        bus(1'b1, timer16_pkg::IDX_CTRL, 8'h0C);
        rd(timer16_pkg::IDX_CTRL, 8'h40, "ctrl low bits");
        bus(1'b1, 12'h100, 8'hFF);
        rd(12'h100, 8'h00, "unmapped");
        rd(timer16_pkg::IDX_GATE, 8'hF2, "gate kept");
    endtask : t_gate

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(timer16_pkg::IDX_MODE, 8'h80, "mode reset");
        rd(timer16_pkg::IDX_CTRL, 8'h40, "ctrl reset");
        rd(timer16_pkg::IDX_GATE, 8'h00, "gate reset");
        t_decode();
        t_run();
        t_gate();
        final_report();
    end
endmodule : timer16_mode_control_regs_tb
